// ---- logic/sdcp_pkg.sv ----
// Constants, opcodes, states and carriers for the single-pin debug command port
// Assumes a 125 MHz core clock and a host using 8N1 characters at the set rate
package sdcp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_HZ      = 125_000_000;
  localparam int          LINK_BAUD   = 6_250_000;
  localparam logic [11:0] BIT_CYC     = 12'(CLK_HZ / LINK_BAUD);
  localparam logic [11:0] HALF_CYC    = 12'(CLK_HZ / LINK_BAUD / 2);
  localparam logic [3:0]  FRAME_BITS  = 4'h0_00A;

  // ****************************************
  // Opcodes and fields
  // ****************************************
  localparam logic [7:0]  OP_CTL_WR   = 8'h0_004;
  localparam logic [7:0]  OP_CTL_RD   = 8'h0_005;
  localparam logic [7:0]  OP_PC_WR    = 8'h0_006;
  localparam logic [7:0]  OP_PC_RD    = 8'h0_007;
  localparam logic [7:0]  OP_RF_WR    = 8'h0_008;
  localparam int          MODE_BIT    = 7;
  localparam logic [7:0]  CTL_RESET   = 8'h0_000;
  localparam logic [15:0] PC_BLOCKED  = 16'hFFFF;
  localparam logic [8:0]  SIZE_FULL   = 9'h0_100;
  localparam logic [11:0] FLASH_LO    = 12'h0_FF8;
  localparam logic [11:0] FLASH_HI    = 12'h0_FFF;

  // ****************************************
  // Buffer
  // ****************************************
  localparam int          BYTE_W      = 8;
  localparam int          FIFO_DEPTH  = 16;

  typedef enum logic [3:0] {
    ST_OP     = 4'h0,
    ST_CTL_W  = 4'h1,
    ST_PC_H   = 4'h2,
    ST_PC_L   = 4'h3,
    ST_RF_AH  = 4'h4,
    ST_RF_AL  = 4'h5,
    ST_RF_SZ  = 4'h6,
    ST_RF_DAT = 4'h7,
    ST_TX     = 4'h8
  } sdcp_cmd_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h2,
    RX_STOP  = 2'h3
  } sdcp_rx_e;

  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
    logic [7:0]  data;
  } sdcp_rf_wr_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } sdcp_pc_wr_s;

endpackage : sdcp_pkg

// ---- logic/sdcp_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides
// Assumes one clock; DEPTH is a power of two
`timescale 1ns/1ns
module sdcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  // Fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign o_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data  = mem_q[rd_q];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_comb
  begin
    wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push)
      mem_q[wr_q] <= i_data;
  end

endmodule : sdcp_fifo

// ---- logic/sdcp_port.sv ----
// Single-pin debug command port: serial link, byte buffer and command decoder
// Assumes the pin is pulled up outside and the host waits for each reply
`timescale 1ns/1ns

// What this block does
// - The link is one open-drain pin carrying 8N1 characters, never receiving while sending.
// - Opcode 04H and one byte load that byte into the debug control register.
// - Under read protection a control write may set the debug mode bit but never clear it.
// - Opcode 05H sends the debug control register back as one byte.
// - Opcode 06H takes the new program counter as high byte then low byte and loads it.
// - Program counter bytes are dropped outside debug mode or under read protection.
// - Opcode 07H returns the program counter high byte first, or FFFFH when blocked.
// - Opcode 08H takes address high nibble, address low byte, size, then the data bytes.
// - A size byte of 0 means 256 data bytes, otherwise the value itself.
// - Outside debug mode register file writes change nothing.
// - Under read protection only flash control registers accept written data.
module sdcp_port (
  // Clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_reset,
  // Debug serial pin
  input  wire logic                 i_debug_serial_pin,
  output logic                      o_debug_serial_pin,
  output logic                      o_debug_serial_pin_oe_n,
  // Device state
  input  wire logic                 i_read_protect,
  input  wire logic [15:0]          i_pc,
  // Control and writes
  output logic [7:0]                o_debug_control_reg,
  output logic                      o_debug_mode_bit,
  output sdcp_pkg::sdcp_pc_wr_s     o_pc_wr,
  output sdcp_pkg::sdcp_rf_wr_s     o_rf_wr,
  output logic                      o_rx_overrun
);

  // ****************************************
  // Receiver
  // ****************************************
  sdcp_pkg::sdcp_rx_e rx_st_q, rx_st_d;
  logic [11:0] rx_tim_q, rx_tim_d;
  logic [2:0]  rx_bit_q, rx_bit_d;
  logic [7:0]  rx_sh_q, rx_sh_d;
  logic        rx_vld_q, rx_vld_d;
  logic        ovr_q, ovr_d;
  logic        tx_busy;
  logic        fifo_ready;

  always_comb
  begin
    rx_st_d  = rx_st_q;
    rx_tim_d = rx_tim_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d  = rx_sh_q;
    rx_vld_d = 1'b0;
    ovr_d    = ovr_q;
    unique case (rx_st_q)
      sdcp_pkg::RX_IDLE:
        if (!i_debug_serial_pin && !tx_busy)
        begin
          rx_st_d  = sdcp_pkg::RX_START;
          rx_tim_d = sdcp_pkg::HALF_CYC;
        end
      sdcp_pkg::RX_START:
        if (rx_tim_q != '0)
          rx_tim_d = 12'(rx_tim_q - 1'b1);
        else if (i_debug_serial_pin)
          rx_st_d = sdcp_pkg::RX_IDLE; // Glitch, not a start bit
        else
        begin
          rx_st_d  = sdcp_pkg::RX_DATA;
          // Sample on zero, so reload one short to keep the bit period exact
          rx_tim_d = 12'(sdcp_pkg::BIT_CYC - 1'b1);
          rx_bit_d = '0;
        end
      sdcp_pkg::RX_DATA:
        if (rx_tim_q != '0)
          rx_tim_d = 12'(rx_tim_q - 1'b1);
        else
        begin
          rx_sh_d  = {i_debug_serial_pin, rx_sh_q[7:1]};
          rx_tim_d = 12'(sdcp_pkg::BIT_CYC - 1'b1);
          rx_bit_d = 3'(rx_bit_q + 1'b1);
          if (rx_bit_q == 3'h7)
            rx_st_d = sdcp_pkg::RX_STOP;
        end
      sdcp_pkg::RX_STOP:
        if (rx_tim_q != '0)
          rx_tim_d = 12'(rx_tim_q - 1'b1);
        else
        begin
          rx_st_d = sdcp_pkg::RX_IDLE;
          // Framing errors drop the byte
          rx_vld_d = i_debug_serial_pin;
        end
    endcase
    // Link cannot be stalled, so a full buffer loses the byte
    if (rx_vld_q && !fifo_ready)
      ovr_d = 1'b1;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      rx_st_q  <= sdcp_pkg::RX_IDLE;
      rx_tim_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q  <= '0;
      rx_vld_q <= 1'b0;
      ovr_q    <= 1'b0;
    end
    else
    begin
      rx_st_q  <= rx_st_d;
      rx_tim_q <= rx_tim_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q  <= rx_sh_d;
      rx_vld_q <= rx_vld_d;
      ovr_q    <= ovr_d;
    end
  end

  // ****************************************
  // Byte buffer
  // ****************************************
  logic       byte_vld;
  logic       byte_take;
  logic [7:0] byte_val;

  sdcp_fifo #(
    .WIDTH (sdcp_pkg::BYTE_W),
    .DEPTH (sdcp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_valid    (rx_vld_q),
    .o_ready    (fifo_ready),
    .i_data     (rx_sh_q),
    .o_valid    (byte_vld),
    .i_ready    (byte_take),
    .o_data     (byte_val)
  );

  // ****************************************
  // Command decoder
  // ****************************************
  sdcp_pkg::sdcp_cmd_e st_q, st_d;
  logic [7:0]  ctl_q, ctl_d;
  logic [7:0]  pch_q, pch_d;
  logic [11:0] addr_q, addr_d;
  logic [8:0]  cnt_q, cnt_d;
  logic [15:0] rsp_q, rsp_d;
  logic [1:0]  rsp_n_q, rsp_n_d;
  sdcp_pkg::sdcp_pc_wr_s pcw_q, pcw_d;
  sdcp_pkg::sdcp_rf_wr_s rfw_q, rfw_d;
  logic        tx_start;
  logic        dbg_ok;

  function automatic logic in_flash(input logic [11:0] a);
    in_flash = (a >= sdcp_pkg::FLASH_LO) && (a <= sdcp_pkg::FLASH_HI);
  endfunction : in_flash

  assign dbg_ok    = ctl_q[sdcp_pkg::MODE_BIT] && !i_read_protect;
  // Decoder stalls during a reply, letting the buffer absorb bytes
  assign byte_take = byte_vld && (st_q != sdcp_pkg::ST_TX);
  assign tx_start  = (st_q == sdcp_pkg::ST_TX) && !tx_busy && (rsp_n_q != '0);

  always_comb
  begin
    st_d    = st_q;
    ctl_d   = ctl_q;
    pch_d   = pch_q;
    addr_d  = addr_q;
    cnt_d   = cnt_q;
    rsp_d   = rsp_q;
    rsp_n_d = rsp_n_q;
    pcw_d   = '0;
    rfw_d   = '0;
    unique case (st_q)
      sdcp_pkg::ST_OP:
        if (byte_take)
          unique case (byte_val)
            sdcp_pkg::OP_CTL_WR: st_d = sdcp_pkg::ST_CTL_W;
            sdcp_pkg::OP_CTL_RD:
            begin
              rsp_d   = {ctl_q, 8'h0_000};
              rsp_n_d = 2'h1;
              st_d    = sdcp_pkg::ST_TX;
            end
            sdcp_pkg::OP_PC_WR: st_d = sdcp_pkg::ST_PC_H;
            sdcp_pkg::OP_PC_RD:
            begin
              rsp_d   = dbg_ok ? i_pc : sdcp_pkg::PC_BLOCKED;
              rsp_n_d = 2'h2;
              st_d    = sdcp_pkg::ST_TX;
            end
            sdcp_pkg::OP_RF_WR: st_d = sdcp_pkg::ST_RF_AH;
            // Unknown opcodes take one byte only
            default: st_d = sdcp_pkg::ST_OP;
          endcase
      sdcp_pkg::ST_CTL_W:
        if (byte_take)
        begin
          ctl_d = byte_val;
          if (i_read_protect && ctl_q[sdcp_pkg::MODE_BIT])
            ctl_d[sdcp_pkg::MODE_BIT] = 1'b1;
          st_d = sdcp_pkg::ST_OP;
        end
      sdcp_pkg::ST_PC_H:
        if (byte_take)
        begin
          pch_d = byte_val;
          st_d  = sdcp_pkg::ST_PC_L;
        end
      sdcp_pkg::ST_PC_L:
        if (byte_take)
        begin
          pcw_d.valid = dbg_ok;
          pcw_d.value = {pch_q, byte_val};
          st_d        = sdcp_pkg::ST_OP;
        end
      sdcp_pkg::ST_RF_AH:
        if (byte_take)
        begin
          addr_d = {byte_val[3:0], 8'h0_000};
          st_d   = sdcp_pkg::ST_RF_AL;
        end
      sdcp_pkg::ST_RF_AL:
        if (byte_take)
        begin
          addr_d = {addr_q[11:8], byte_val};
          st_d   = sdcp_pkg::ST_RF_SZ;
        end
      sdcp_pkg::ST_RF_SZ:
        if (byte_take)
        begin
          cnt_d = (byte_val == '0) ? sdcp_pkg::SIZE_FULL : {1'b0, byte_val};
          st_d  = sdcp_pkg::ST_RF_DAT;
        end
      sdcp_pkg::ST_RF_DAT:
        if (byte_take)
        begin
          rfw_d.valid = ctl_q[sdcp_pkg::MODE_BIT]
                        && (!i_read_protect || in_flash(addr_q));
          rfw_d.addr  = addr_q;
          rfw_d.data  = byte_val;
          addr_d      = 12'(addr_q + 1'b1);
          cnt_d       = 9'(cnt_q - 1'b1);
          if (cnt_q == 9'h0_001)
            st_d = sdcp_pkg::ST_OP;
        end
      sdcp_pkg::ST_TX:
        if (tx_start)
        begin
          rsp_d   = {rsp_q[7:0], 8'h0_000};
          rsp_n_d = 2'(rsp_n_q - 1'b1);
        end
        else if (!tx_busy && rsp_n_q == '0)
          st_d = sdcp_pkg::ST_OP;
      default: st_d = sdcp_pkg::ST_OP;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      st_q    <= sdcp_pkg::ST_OP;
      ctl_q   <= sdcp_pkg::CTL_RESET;
      pch_q   <= '0;
      addr_q  <= '0;
      cnt_q   <= '0;
      rsp_q   <= '0;
      rsp_n_q <= '0;
      pcw_q   <= '0;
      rfw_q   <= '0;
    end
    else
    begin
      st_q    <= st_d;
      ctl_q   <= ctl_d;
      pch_q   <= pch_d;
      addr_q  <= addr_d;
      cnt_q   <= cnt_d;
      rsp_q   <= rsp_d;
      rsp_n_q <= rsp_n_d;
      pcw_q   <= pcw_d;
      rfw_q   <= rfw_d;
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  logic [9:0]  tx_sh_q, tx_sh_d;
  logic [3:0]  tx_bits_q, tx_bits_d;
  logic [11:0] tx_tim_q, tx_tim_d;

  assign tx_busy = (tx_bits_q != '0);

  always_comb
  begin
    tx_sh_d   = tx_sh_q;
    tx_bits_d = tx_bits_q;
    tx_tim_d  = tx_tim_q;
    if (tx_start)
    begin
      tx_sh_d   = {1'b1, rsp_q[15:8], 1'b0};
      tx_bits_d = sdcp_pkg::FRAME_BITS;
      tx_tim_d  = sdcp_pkg::BIT_CYC;
    end
    else if (tx_busy)
    begin
      if (tx_tim_q != 12'h0_001)
        tx_tim_d = 12'(tx_tim_q - 1'b1);
      else
      begin
        tx_sh_d   = {1'b1, tx_sh_q[9:1]};
        tx_bits_d = 4'(tx_bits_q - 1'b1);
        tx_tim_d  = sdcp_pkg::BIT_CYC;
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      tx_sh_q   <= '1;
      tx_bits_q <= '0;
      tx_tim_q  <= '0;
    end
    else
    begin
      tx_sh_q   <= tx_sh_d;
      tx_bits_q <= tx_bits_d;
      tx_tim_q  <= tx_tim_d;
    end
  end

  // Open drain: only zero bits pull the pin, ones are left to the pull-up
  assign o_debug_serial_pin      = 1'b0;
  assign o_debug_serial_pin_oe_n = !(tx_busy && !tx_sh_q[0]);
  assign o_debug_control_reg     = ctl_q;
  assign o_debug_mode_bit        = ctl_q[sdcp_pkg::MODE_BIT];
  assign o_pc_wr                 = pcw_q;
  assign o_rf_wr                 = rfw_q;
  assign o_rx_overrun            = ovr_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence op_taken(logic [7:0] op);
    st_q == sdcp_pkg::ST_OP && byte_take && byte_val == op;
  endsequence

  half_duplex_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    tx_busy |-> rx_st_q == sdcp_pkg::RX_IDLE) else $error("Receive during transmit");
  ctl_load_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    st_q == sdcp_pkg::ST_CTL_W && byte_take && !i_read_protect
    |=> ctl_q == $past(byte_val)) else $error("Control byte not loaded");
  mode_sticky_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_read_protect && ctl_q[7] |=> ctl_q[7]) else $error("Mode bit cleared under protect");
  ctl_reply_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    op_taken(sdcp_pkg::OP_CTL_RD) |=> rsp_n_q == 2'h1 && rsp_q[15:8] == $past(ctl_q))
    else $error("Control reply wrong");
  pc_gate_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    pcw_q.valid |-> $past(st_q == sdcp_pkg::ST_PC_L && dbg_ok))
    else $error("Program counter written while blocked");
  pc_order_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    pcw_q.valid |-> pcw_q.value[15:8] == $past(pch_q)) else $error("Program counter bytes swapped");
  pc_blocked_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    op_taken(sdcp_pkg::OP_PC_RD) ##0 !dbg_ok |=> rsp_q == 16'hFFFF && rsp_n_q == 2'h2)
    else $error("Blocked program counter read not FFFF");
  size_zero_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    st_q == sdcp_pkg::ST_RF_SZ && byte_take && byte_val == 8'h0_000 |=> cnt_q == 9'h0_100)
    else $error("Size zero not 256");
  rf_gate_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    rfw_q.valid |-> $past(ctl_q[7]) && (!$past(i_read_protect) || in_flash(rfw_q.addr)))
    else $error("Register write not allowed");
  rf_consume_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    st_q == sdcp_pkg::ST_RF_DAT && byte_take && cnt_q == 9'h0_001 |=> st_q == sdcp_pkg::ST_OP)
    else $error("Data count not consumed");

endmodule : sdcp_port

// ---- tb/sdcp_host.sv ----
// Debug host model: sends and receives 8N1 characters on the shared pin
// Assumes the pin is a pulled-up wired-AND of this model and the device
`timescale 1ns/1ns
module sdcp_host (
  // Clock and pin
  input  wire logic i_core_clk,
  input  wire logic i_pin,
  output logic      o_pin_oe_n
);
  localparam int BIT  = int'(sdcp_pkg::BIT_CYC);
  localparam int HALF = int'(sdcp_pkg::HALF_CYC);

  initial o_pin_oe_n = 1'b1;

  // ****************************************
  // Send one character
  // ****************************************
  // Stop bit is cut to half and finished at the next call, so a reply is never missed
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    repeat (HALF) @(posedge i_core_clk);
    for (int i = 0; i < 10; i++)
    begin
      #1 o_pin_oe_n = frame[i];
      repeat ((i == 9) ? HALF : BIT) @(posedge i_core_clk);
    end
  endtask : send_byte

  // ****************************************
  // Receive one character
  // ****************************************
  // Host stays released while the device answers
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n  = 0;
    ok = 1'b1;
    while (i_pin !== 1'b0 && n < 4 * BIT)
    begin
      @(posedge i_core_clk);
      n++;
    end
    if (n >= 4 * BIT) ok = 1'b0;
    repeat (HALF) @(posedge i_core_clk);
    if (i_pin !== 1'b0) ok = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge i_core_clk);
      b[i] = i_pin;
    end
    repeat (BIT) @(posedge i_core_clk);
    if (i_pin !== 1'b1) ok = 1'b0;
  endtask : recv_byte
endmodule : sdcp_host

// ---- tb/test_single_pin_debug_command_port.sv ----
// Testbench for the debug command port, talking through the host model
// Assumes the design holds the bit rate in its package; runs near 61k cycles
`timescale 1ns/1ns
module test_single_pin_debug_command_port;
  logic                  clk;
  logic                  rst;
  logic                  prot;
  logic [15:0]           pc;
  logic                  dev_out;
  logic                  dev_oe_n;
  logic                  host_oe_n;
  logic                  pin;
  logic [7:0]            ctl;
  logic                  mode;
  logic                  ovr;
  sdcp_pkg::sdcp_pc_wr_s pc_wr;
  sdcp_pkg::sdcp_rf_wr_s rf_wr;
  int                    error_cnt;
  int                    n_compared;
  int                    cyc;
  int                    pc_cnt;
  int                    rf_cnt;
  logic [15:0]           pc_last;
  logic [19:0]           rf_last;
  logic [7:0]            rb;
  logic                  ok;

  // Pull-up wins unless someone pulls low
  assign pin = dev_oe_n & host_oe_n;

  initial clk = 1'b0;
  always #4 clk = ~clk;

  sdcp_port i_sdcp_port (
    .i_core_clk              (clk),
    .i_reset                 (rst),
    .i_debug_serial_pin      (pin),
    .o_debug_serial_pin      (dev_out),
    .o_debug_serial_pin_oe_n (dev_oe_n),
    .i_read_protect          (prot),
    .i_pc                    (pc),
    .o_debug_control_reg     (ctl),
    .o_debug_mode_bit        (mode),
    .o_pc_wr                 (pc_wr),
    .o_rf_wr                 (rf_wr),
    .o_rx_overrun            (ovr)
  );

  sdcp_host i_sdcp_host (
    .i_core_clk (clk),
    .i_pin      (pin),
    .o_pin_oe_n (host_oe_n)
  );

  // ****************************************
  // Monitors and timeout
  // ****************************************
  // Pulses are one cycle wide, so they are counted rather than polled
  always @(posedge clk)
  begin
    cyc++;
    if (pc_wr.valid === 1'b1)
    begin
      pc_cnt++;
      pc_last = pc_wr.value;
    end
    if (rf_wr.valid === 1'b1)
    begin
      rf_cnt++;
      rf_last = {rf_wr.addr, rf_wr.data};
    end
    if (cyc == 80000)
    begin
      error_cnt++;
      results();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tx(input logic [7:0] b);
    i_sdcp_host.send_byte(b);
    repeat (30) @(posedge clk);
  endtask : tx

  task automatic results;
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_ctl;
    tx(sdcp_pkg::OP_CTL_WR);
    tx(8'h0_080);
    check(32'(ctl), 32'h0_080);
    check(32'(mode), 32'h0_001);
    // Reply starts within a few cycles, so no settling wait before listening
    i_sdcp_host.send_byte(sdcp_pkg::OP_CTL_RD);
    i_sdcp_host.recv_byte(rb, ok);
    check(32'({ok, rb}), 32'h0_180);
  endtask : t_ctl

  task automatic t_pc;
    tx(sdcp_pkg::OP_PC_WR);
    tx(8'h0_012);
    tx(8'h0_034);
    check(32'({pc_cnt[3:0], pc_last}), 32'h1_1234);
    i_sdcp_host.send_byte(sdcp_pkg::OP_PC_RD);
    i_sdcp_host.recv_byte(rb, ok);
    check(32'({ok, rb}), 32'h0_1AB);
    i_sdcp_host.recv_byte(rb, ok);
    check(32'({ok, rb}), 32'h0_1CD);
  endtask : t_pc

  task automatic t_prot;
    #1 prot = 1'b1;
    tx(sdcp_pkg::OP_CTL_WR);
    tx(8'h0_000);
    check(32'(ctl), 32'h0_080);
    tx(sdcp_pkg::OP_PC_WR);
    tx(8'h0_056);
    tx(8'h0_078);
    check(32'(pc_cnt), 32'h0_001);
    i_sdcp_host.send_byte(sdcp_pkg::OP_PC_RD);
    i_sdcp_host.recv_byte(rb, ok);
    check(32'({ok, rb}), 32'h0_1FF);
    i_sdcp_host.recv_byte(rb, ok);
    check(32'({ok, rb}), 32'h0_1FF);
  endtask : t_prot

  // Flash control address still accepted under protection
  task automatic t_rf;
    tx(sdcp_pkg::OP_RF_WR);
    tx(8'h0_00F);
    tx(8'h0_0F8);
    tx(8'h0_001);
    tx(8'h0_0AA);
    check(32'(rf_cnt), 32'h0_001);
    check(32'(rf_last), 32'h0_FF8AA);
    check(32'(ovr), 32'h0_000);
  endtask : t_rf

  // Size zero from the flash window: 256 bytes, only the window is written
  task automatic t_size;
    int base;
    base = rf_cnt;
    tx(sdcp_pkg::OP_RF_WR);
    tx(8'h0_00F);
    tx(8'h0_0F8);
    tx(8'h0_000);
    for (int i = 0; i < 256; i++)
      i_sdcp_host.send_byte(8'(i));
    repeat (30) @(posedge clk);
    check(32'(rf_cnt - base), 32'(sdcp_pkg::FLASH_HI - sdcp_pkg::FLASH_LO) + 32'h0_001);
    check(32'(rf_last), 32'({sdcp_pkg::FLASH_HI, 8'h0_007}));
    i_sdcp_host.send_byte(sdcp_pkg::OP_CTL_RD);
    i_sdcp_host.recv_byte(rb, ok);
    check(32'({ok, rb}), 32'h0_180);
  endtask : t_size

  // Reset in mid-run leaves debug mode; register file and program counter writes are then refused
  task automatic t_reset;
    int rf_base;
    int pc_base;
    rf_base = rf_cnt;
    pc_base = pc_cnt;
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    prot = 1'b0;
    check(32'({dev_out, dev_oe_n, ctl}), 32'h0_100);
    tx(sdcp_pkg::OP_RF_WR);
    tx(8'h0_00F);
    tx(8'h0_0F9);
    tx(8'h0_001);
    tx(8'h0_055);
    check(32'(rf_cnt - rf_base), 32'h0_000);
    tx(sdcp_pkg::OP_PC_WR);
    tx(8'h0_012);
    tx(8'h0_034);
    check(32'(pc_cnt - pc_base), 32'h0_000);
    #1 prot = 1'b1;
    tx(sdcp_pkg::OP_CTL_WR);
    tx(8'h0_080);
    check(32'(ctl), 32'h0_080);
    tx(8'h0_03C);
    i_sdcp_host.send_byte(sdcp_pkg::OP_CTL_RD);
    i_sdcp_host.recv_byte(rb, ok);
    check(32'({ok, rb}), 32'h0_180);
  endtask : t_reset

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    error_cnt  = 0;
    n_compared = 0;
    cyc        = 0;
    pc_cnt     = 0;
    rf_cnt     = 0;
    pc_last    = 16'h0_000;
    rf_last    = 20'h0_0000;
    rst        = 1'b1;
    prot       = 1'b0;
    pc         = 16'hABCD;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    check(32'({dev_out, dev_oe_n, ctl}), 32'h0_100);
    t_ctl();
    t_pc();
    t_prot();
    t_rf();
    t_size();
    t_reset();
    results();
  end
endmodule : test_single_pin_debug_command_port
